/* File: verilog/rx_sync_ook_config_regs.sv */
`default_nettype none
// Functional notes
// [RL1] upper polyphase nibble sets centre, default 0011
// [RL2] host keeps reserved low nibble non-zero
// [RL3] bit7 polyphase filter on, OOK receive only
// [RL4] bit6 set disables bit synchronizer
// [RL5] bit5 enables pattern recognition, off at reset
// [RL6] bits4-3 select 8/16/24/32 bit pattern
// [RL7] bits2-1 tolerated bit errors 0..3
// [RL8] host leaves sync bit0 at zero
// [RL9] host keeps reserved register non-zero
// [RL10] strength readout read-only, 0.55 dB steps
// [RL11] software computes 0.55 times value minus 118.5
// [RL12] strength shows live measurement, no reset value
// [RL13] bits7-5 select OOK threshold step size
// [RL14] bits4-2 select OOK threshold decrement rate
// [RL15] bits1-0 averaging cutoff; 01/10 not allowed
// [RL16] pattern bytes 31:24, 23:16 at 0x16, 0x17
// [RL17] pattern bytes 15:8, 7:0 at 0x18, 0x19
// [RL18] automatic fill starts FIFO loading on match
// [RL19] match when errors within tolerance over length
// [RL20] writable fields reset to defaults, read back
module rx_sync_ook_config_regs
  import rx_cfg_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic [rx_cfg_pkg::ADDR_W-1:0] address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [3:0]                byteenable,
  input  wire logic [rx_cfg_pkg::DATA_W-1:0] writedata,
  output logic      [rx_cfg_pkg::DATA_W-1:0] readdata,
  output logic                           waitrequest,
  input  wire logic [7:0]                signal_strength_in,
  input  wire logic                      rx_bit_valid,
  input  wire logic                      rx_bit,
  input  wire logic                      ook_receive,
  input  wire logic                      buffered_mode,
  output logic      [3:0]                polyphase_centre_code,
  output logic                           polyphase_filter_on,
  output logic                           bit_synchronizer_disable,
  output logic      [2:0]                ook_threshold_step,
  output logic      [2:0]                ook_threshold_rate,
  output logic      [1:0]                ook_average_cutoff,
  output logic                           pattern_match,
  output logic                           fifo_fill_active
);
  import rx_cfg_pkg::*;

  logic [7:0] polyphase_filter_config_reg;
  logic [7:0] sync_control_reg;
  logic [7:0] reserved_nonzero_reg;
  logic [7:0] ook_threshold_config_reg;
  logic [7:0] sync_pattern_byte3_reg;
  logic [7:0] sync_pattern_byte2_reg;
  logic [7:0] sync_pattern_byte1_reg;
  logic [7:0] sync_pattern_byte0_reg;
  logic [7:0] fill_control_reg;
  logic [7:0] strength_meta_reg;
  logic [7:0] strength_sync_reg;
  logic       ook_receive_meta_reg;
  logic       ook_receive_reg;
  logic       buffered_meta_reg;
  logic       buffered_reg;
  logic       bit_valid_meta_reg;
  logic       bit_valid_sync_reg;
  logic       bit_meta_reg;
  logic       bit_sync_reg;
  logic       bit_valid_prev_reg;
  logic       bit_strobe;
  logic       match_pulse;
  logic       match_seen_reg;
  logic       answered_reg;
  logic       access;
  logic       wr_take;
  logic       fill_start_req;
  logic [5:0] index;
  logic [7:0] read_byte;
  logic [31:0] pattern;

  assign access = (read || write) && !answered_reg;
  assign wr_take = write && answered_reg;
  assign index = address[7:2];
  assign pattern = {sync_pattern_byte3_reg, sync_pattern_byte2_reg,
                    sync_pattern_byte1_reg, sync_pattern_byte0_reg};

  // one wait cycle per access; answer on the second edge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      answered_reg <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      answered_reg <= access;
      waitrequest <= !access;
    end
  end

  // external pins pass two flip-flops
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ook_receive_meta_reg <= 1'b0;
      ook_receive_reg <= 1'b0;
      buffered_meta_reg <= 1'b0;
      buffered_reg <= 1'b0;
      bit_valid_meta_reg <= 1'b0;
      bit_valid_sync_reg <= 1'b0;
      bit_meta_reg <= 1'b0;
      bit_sync_reg <= 1'b0;
      bit_valid_prev_reg <= 1'b0;
    end else begin
      ook_receive_meta_reg <= ook_receive;
      ook_receive_reg <= ook_receive_meta_reg;
      buffered_meta_reg <= buffered_mode;
      buffered_reg <= buffered_meta_reg;
      bit_valid_meta_reg <= rx_bit_valid;
      bit_valid_sync_reg <= bit_valid_meta_reg;
      bit_meta_reg <= rx_bit;
      bit_sync_reg <= bit_meta_reg;
      bit_valid_prev_reg <= bit_valid_sync_reg;
    end
  end

  assign bit_strobe = bit_valid_sync_reg && !bit_valid_prev_reg;

  // live measurement, never reset
  always_ff @(posedge clock) begin
    strength_meta_reg <= signal_strength_in;
    strength_sync_reg <= strength_meta_reg; // [RL12]
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      polyphase_filter_config_reg <= RST_POLY; // [RL1] [RL20]
      sync_control_reg <= RST_SYNC; // [RL5] [RL6] [RL7]
      reserved_nonzero_reg <= RST_RESV;
      ook_threshold_config_reg <= RST_OOK;
      sync_pattern_byte3_reg <= RST_PAT; // [RL16]
      sync_pattern_byte2_reg <= RST_PAT;
      sync_pattern_byte1_reg <= RST_PAT; // [RL17]
      sync_pattern_byte0_reg <= RST_PAT;
    end else if (wr_take && byteenable[0]) begin
      if (index == IDX_POLY[5:0]) begin
        polyphase_filter_config_reg <= writedata[7:0];
      end else if (index == IDX_SYNC[5:0]) begin
        sync_control_reg <= writedata[7:0];
      end else if (index == IDX_RESV[5:0]) begin
        reserved_nonzero_reg <= writedata[7:0];
      end else if (index == IDX_OOK[5:0]) begin
        ook_threshold_config_reg <= writedata[7:0];
      end else if (index == IDX_PAT3[5:0]) begin
        sync_pattern_byte3_reg <= writedata[7:0]; // [RL16]
      end else if (index == IDX_PAT2[5:0]) begin
        sync_pattern_byte2_reg <= writedata[7:0];
      end else if (index == IDX_PAT1[5:0]) begin
        sync_pattern_byte1_reg <= writedata[7:0]; // [RL17]
      end else if (index == IDX_PAT0[5:0]) begin
        sync_pattern_byte0_reg <= writedata[7:0];
      end
    end
  end

  assign fill_start_req = wr_take && byteenable[0] && (index == IDX_FILL[5:0])
                          && writedata[FILL_START_BIT];

  // bit0 manual fill, bit1 fill status; match sets win over clears
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fill_control_reg <= RST_FILL;
    end else begin
      if (wr_take && byteenable[0] && index == IDX_FILL[5:0]) begin
        fill_control_reg[FILL_MANUAL_BIT] <= writedata[FILL_MANUAL_BIT];
      end
      if (buffered_reg && !fill_control_reg[FILL_MANUAL_BIT] && match_pulse) begin
        fill_control_reg[FILL_START_BIT] <= 1'b1; // [RL18]
      end else if (fill_control_reg[FILL_MANUAL_BIT] && fill_start_req) begin
        fill_control_reg[FILL_START_BIT] <= 1'b1;
      end else if (wr_take && byteenable[0] && index == IDX_FILL[5:0]) begin
        fill_control_reg[FILL_START_BIT] <= 1'b0;
      end
    end
  end

  pattern_matcher u_matcher (
    .clock         (clock),
    .rst_b         (rst_b),
    .enable        (sync_control_reg[SYNC_RECOG_BIT]), // [RL5]
    .bit_valid     (bit_strobe),
    .bit_in        (bit_sync_reg),
    .length_select (sync_control_reg[SYNC_LEN_LSB +: 2]), // [RL6]
    .tolerance     (sync_control_reg[SYNC_TOL_LSB +: 2]), // [RL7]
    .pattern       (pattern),
    .match         (match_pulse)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      match_seen_reg <= 1'b0;
    end else if (match_pulse) begin
      match_seen_reg <= 1'b1;
    end else if (wr_take && index == IDX_MATCH[5:0] && byteenable[0] && writedata[0]) begin
      match_seen_reg <= 1'b0;
    end
  end

  always_comb begin
    if (index == IDX_POLY[5:0]) begin
      read_byte = polyphase_filter_config_reg;
    end else if (index == IDX_SYNC[5:0]) begin
      read_byte = sync_control_reg;
    end else if (index == IDX_RESV[5:0]) begin
      read_byte = reserved_nonzero_reg;
    end else if (index == IDX_RSSI[5:0]) begin
      read_byte = strength_sync_reg; // [RL10]
    end else if (index == IDX_OOK[5:0]) begin
      read_byte = ook_threshold_config_reg;
    end else if (index == IDX_PAT3[5:0]) begin
      read_byte = sync_pattern_byte3_reg;
    end else if (index == IDX_PAT2[5:0]) begin
      read_byte = sync_pattern_byte2_reg;
    end else if (index == IDX_PAT1[5:0]) begin
      read_byte = sync_pattern_byte1_reg;
    end else if (index == IDX_PAT0[5:0]) begin
      read_byte = sync_pattern_byte0_reg;
    end else if (index == IDX_FILL[5:0]) begin
      read_byte = fill_control_reg;
    end else if (index == IDX_MATCH[5:0]) begin
      read_byte = {7'h00, match_seen_reg};
    end else begin
      read_byte = UNMAPPED_DATA[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      readdata <= UNMAPPED_DATA;
    end else if (read && !answered_reg) begin
      readdata <= {24'h00_0000, read_byte}; // [RL20]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      polyphase_centre_code <= RST_POLY[7:4];
      polyphase_filter_on <= 1'b0;
      bit_synchronizer_disable <= 1'b0;
      ook_threshold_step <= 3'h0;
      ook_threshold_rate <= 3'h0;
      ook_average_cutoff <= CUT_HIGH;
      pattern_match <= 1'b0;
      fifo_fill_active <= 1'b0;
    end else begin
      polyphase_centre_code <= polyphase_filter_config_reg[POLY_CODE_LSB +: 4]; // [RL1]
      polyphase_filter_on <= sync_control_reg[SYNC_FILTER_BIT] && ook_receive_reg; // [RL3]
      bit_synchronizer_disable <= sync_control_reg[SYNC_BSYNC_DIS_BIT]; // [RL4]
      ook_threshold_step <= ook_threshold_config_reg[OOK_STEP_LSB +: 3]; // [RL13]
      ook_threshold_rate <= ook_threshold_config_reg[OOK_RATE_LSB +: 3]; // [RL14]
      // reserved cut-off codes fall back to the default
      if (ook_threshold_config_reg[OOK_CUT_LSB +: 2] == CUT_LOW) begin
        ook_average_cutoff <= CUT_LOW; // [RL15]
      end else begin
        ook_average_cutoff <= CUT_HIGH;
      end
      pattern_match <= match_pulse;
      fifo_fill_active <= fill_control_reg[FILL_START_BIT] && buffered_reg;
    end
  end

  property p_wait_one;
    @(posedge clock) disable iff (!rst_b)
      ($rose(read) && !answered_reg) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer not after one wait"); // [RL20]

  property p_filter_gate;
    @(posedge clock) disable iff (!rst_b)
      !ook_receive_reg |=> !polyphase_filter_on;
  endproperty
  a_filter_gate: assert property (p_filter_gate) else $error("filter on outside OOK"); // [RL3]

  property p_bsync;
    @(posedge clock) disable iff (!rst_b)
      1'b1 |=> bit_synchronizer_disable == $past(sync_control_reg[SYNC_BSYNC_DIS_BIT]);
  endproperty
  a_bsync: assert property (p_bsync) else $error("bit sync control wrong"); // [RL4]

  property p_no_match_off;
    @(posedge clock) disable iff (!rst_b)
      !sync_control_reg[SYNC_RECOG_BIT] |=> !match_pulse;
  endproperty
  a_no_match_off: assert property (p_no_match_off) else $error("match while off"); // [RL5]

  property p_cutoff_legal;
    @(posedge clock) disable iff (!rst_b)
      ook_threshold_config_reg[OOK_CUT_LSB +: 2] != CUT_LOW |=> ook_average_cutoff == CUT_HIGH;
  endproperty
  a_cutoff_legal: assert property (p_cutoff_legal) else $error("illegal cut-off"); // [RL15]

  sequence s_auto_match;
    buffered_reg && !fill_control_reg[FILL_MANUAL_BIT] && match_pulse;
  endsequence
  property p_auto_fill;
    @(posedge clock) disable iff (!rst_b)
      s_auto_match |=> fill_control_reg[FILL_START_BIT] ##1 fifo_fill_active;
  endproperty
  a_auto_fill: assert property (p_auto_fill) else $error("fill not started"); // [RL18]

  property p_centre;
    @(posedge clock) disable iff (!rst_b)
      1'b1 |=> polyphase_centre_code
        == $past(polyphase_filter_config_reg[POLY_CODE_LSB +: 4]);
  endproperty
  a_centre: assert property (p_centre) else $error("centre code wrong"); // [RL1]

  property p_step;
    @(posedge clock) disable iff (!rst_b)
      1'b1 |=> ook_threshold_step == $past(ook_threshold_config_reg[7:5])
        && ook_threshold_rate == $past(ook_threshold_config_reg[4:2]);
  endproperty
  a_step: assert property (p_step) else $error("OOK step or rate wrong"); // [RL13]
endmodule
`default_nettype wire

/* File: verilog/rx_cfg_pkg.sv */
`default_nettype none
package rx_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POLY = 8'h11;
  localparam logic [7:0] IDX_SYNC = 8'h12;
  localparam logic [7:0] IDX_RESV = 8'h13;
  localparam logic [7:0] IDX_RSSI = 8'h14;
  localparam logic [7:0] IDX_OOK = 8'h15;
  localparam logic [7:0] IDX_PAT3 = 8'h16;
  localparam logic [7:0] IDX_PAT2 = 8'h17;
  localparam logic [7:0] IDX_PAT1 = 8'h18;
  localparam logic [7:0] IDX_PAT0 = 8'h19;
  localparam logic [7:0] IDX_FILL = 8'h1A;
  localparam logic [7:0] IDX_MATCH = 8'h1B;
  localparam logic [7:0] RST_POLY = 8'h38;
  localparam logic [7:0] RST_SYNC = 8'h18;
  localparam logic [7:0] RST_RESV = 8'h07;
  localparam logic [7:0] RST_OOK = 8'h00;
  localparam logic [7:0] RST_PAT = 8'h00;
  localparam logic [7:0] RST_FILL = 8'h00;
  localparam int POLY_CODE_LSB = 4;
  localparam int SYNC_FILTER_BIT = 7;
  localparam int SYNC_BSYNC_DIS_BIT = 6;
  localparam int SYNC_RECOG_BIT = 5;
  localparam int SYNC_LEN_LSB = 3;
  localparam int SYNC_TOL_LSB = 1;
  localparam int OOK_STEP_LSB = 5;
  localparam int OOK_RATE_LSB = 2;
  localparam int OOK_CUT_LSB = 0;
  localparam int FILL_MANUAL_BIT = 0;
  localparam int FILL_START_BIT = 1;
  localparam logic [1:0] CUT_LOW = 2'h3;
  localparam logic [1:0] CUT_HIGH = 2'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: verilog/pattern_matcher.sv */
`default_nettype none
module pattern_matcher
  import rx_cfg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        enable,
  input  wire logic        bit_valid,
  input  wire logic        bit_in,
  input  wire logic [1:0]  length_select,
  input  wire logic [1:0]  tolerance,
  input  wire logic [31:0] pattern,
  output logic             match
);
  logic [31:0] shift_reg;
  logic [31:0] window;
  logic [31:0] diff;
  logic [31:0] mask;
  logic [5:0]  errors;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shift_reg <= 32'h0000_0000;
    end else if (bit_valid) begin
      shift_reg <= {shift_reg[30:0], bit_in};
    end
  end

  // newest n bits, the arriving one included, against the top n pattern bits
  always_comb begin
    window = {shift_reg[30:0], bit_in};
    case (length_select)
      2'h0: mask = 32'h0000_00FF;
      2'h1: mask = 32'h0000_FFFF;
      2'h2: mask = 32'h00FF_FFFF;
      default: mask = 32'hFFFF_FFFF;
    endcase
    case (length_select)
      2'h0: diff = (window ^ {24'h00_0000, pattern[31:24]}) & mask;
      2'h1: diff = (window ^ {16'h0000, pattern[31:16]}) & mask;
      2'h2: diff = (window ^ {8'h00, pattern[31:8]}) & mask;
      default: diff = (window ^ pattern) & mask;
    endcase
    errors = 6'h00;
    for (int i = 0; i < 32; i++) begin
      errors = errors + {5'h00, diff[i]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      match <= 1'b0;
    end else begin
      match <= enable && bit_valid && (errors <= {4'h0, tolerance}); // [RL19]
    end
  end
endmodule
`default_nettype wire

/* File: dv/avalon_host.sv */
`default_nettype none
module avalon_host
  import rx_cfg_pkg::*;
(
  input  wire logic        clock,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [3:0]       byteenable,
  output logic [31:0]      writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
  end

  // one access; request held until the edge that sees waitrequest low
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    // a host never writes a reserved field illegally
    if (wr && ((idx == IDX_POLY && d[3:0] == 4'h0) ||
               (idx == IDX_SYNC && d[0]) ||
               (idx == IDX_RESV && d == 8'h00) ||
               (idx == IDX_OOK && d[1] != d[0])))
      tb.end_of_test(1'b1);
    @(posedge clock);
    address <= {idx[5:0], 2'h0};
    writedata <= {24'h0, d};
    byteenable <= 4'hF;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    if (waitrequest !== 1'b0)
      tb.end_of_test(1'b1);
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_cfg_pkg::*;

  logic        clock, rst_b, read, write, waitrequest;
  logic [7:0]  address, signal_strength_in;
  logic [3:0]  byteenable, polyphase_centre_code;
  logic [31:0] writedata, readdata, hist, pat, rq;
  logic        rx_bit_valid, rx_bit, ook_receive, buffered_mode;
  logic        polyphase_filter_on, bit_synchronizer_disable, pattern_match, fifo_fill_active;
  logic [2:0]  ook_threshold_step, ook_threshold_rate;
  logic [1:0]  ook_average_cutoff;
  int          error_cnt, n_compared, seen_cnt, exp_match, nbits;
  logic [7:0]  ridx [12] = '{8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
                             8'h1A, 8'h1B, 8'h14, 8'h30};
  logic [7:0]  rexp [12] = '{8'h38, 8'h18, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h5A, 8'h00};
  logic [7:0]  wval [12] = '{8'hC9, 8'hDE, 8'h81, 8'hE3, 8'hA5, 8'h3C, 8'h81, 8'h7E,
                             8'h00, 8'h00, 8'h11, 8'hFF};
  logic [23:0] cases [6] = '{{8'h20, 16'h00A5}, {8'h2A, 16'hA53D}, {8'h28, 16'hA53D},
                             {8'h0A, 16'h00A5}, {8'h34, 16'hA53C}, {8'h3E, 16'h817E}};

  rx_sync_ook_config_regs dut (.clock, .rst_b, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .signal_strength_in, .rx_bit_valid, .rx_bit,
    .ook_receive, .buffered_mode, .polyphase_centre_code, .polyphase_filter_on,
    .bit_synchronizer_disable, .ook_threshold_step, .ook_threshold_rate,
    .ook_average_cutoff, .pattern_match, .fifo_fill_active);

  avalon_host host (.clock, .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (pattern_match === 1'b1)
      seen_cnt++;
  end

  task automatic end_of_test(input logic hung);
    if (hung)
      error_cnt++;
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    host.access(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    host.access(1'b0, idx, 8'h00, q);
    chk($sformatf("register %h", idx), q, {24'h0, exp});
  endtask

  // one received bit; the model predicts whether it completes a pattern
  task automatic send_bit(input logic b, input logic [7:0] ctl);
    int n;
    logic [31:0] diff;
    n = 8 * (int'(ctl[4:3]) + 1);
    rx_bit <= b;
    repeat (2) @(posedge clock);
    rx_bit_valid <= 1'b1;
    repeat (4) @(posedge clock);
    rx_bit_valid <= 1'b0;
    repeat (4) @(posedge clock);
    hist = {hist[30:0], b};
    nbits++;
    diff = (hist ^ (pat >> (32 - n))) << (32 - n);
    if (ctl[5] && nbits >= n && $countones(diff) <= int'(ctl[2:1]))
      exp_match++;
  endtask

  initial begin
    rst_b = 1'b0;
    signal_strength_in = 8'h5A;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    ook_receive = 1'b0;
    buffered_mode = 1'b1;
    hist = 32'h0;
    pat = 32'hA53C817E;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    chk("centre code", polyphase_centre_code, 4'h3);
    chk("bit sync disable", bit_synchronizer_disable, 1'b0);
    for (int i = 0; i < 12; i++)
      rdc(ridx[i], rexp[i]);
    for (int i = 0; i < 12; i++)
      wr(ridx[i], wval[i]);
    signal_strength_in <= 8'hC3;
    for (int i = 0; i < 12; i++)
      rdc(ridx[i], (i == 10) ? 8'hC3 : (i >= 8) ? rexp[i] : wval[i]);
    // host side conversion of the strength reading, in quarter dBm
    host.access(1'b0, IDX_RSSI, 8'h00, rq);
    chk("strength dbm x4", int'(4.0 * (0.55 * real'(rq[7:0]) - 118.5)), -45);
    chk("centre code", polyphase_centre_code, 4'hC);
    chk("filter on", polyphase_filter_on, 1'b0);
    chk("bit sync disable", bit_synchronizer_disable, 1'b1);
    chk("cutoff", ook_average_cutoff, 2'h3);
    ook_receive <= 1'b1;
    repeat (5) @(posedge clock);
    chk("filter on", polyphase_filter_on, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_OOK, {i[2:0], ~i[2:0], 2'h0});
      repeat (2) @(posedge clock);
      chk("threshold step", ook_threshold_step, i[2:0]);
      chk("threshold rate", ook_threshold_rate, 3'(~i[2:0]));
      chk("cutoff", ook_average_cutoff, 2'h0);
    end
    for (int c = 0; c < 6; c++) begin
      wr(IDX_SYNC, cases[c][23:16]);
      for (int b = 15; b >= 0; b--)
        send_bit(cases[c][b], cases[c][23:16]);
      repeat (10) @(posedge clock);
      chk("match count", seen_cnt, exp_match);
    end
    chk("fifo fill", fifo_fill_active, 1'b1);
    rdc(IDX_FILL, 8'h02);
    rdc(IDX_MATCH, 8'h01);
    wr(IDX_FILL, 8'h00);
    wr(IDX_MATCH, 8'h01);
    rdc(IDX_MATCH, 8'h00);
    chk("fifo fill", fifo_fill_active, 1'b0);
    wr(IDX_FILL, 8'h01);
    wr(IDX_FILL, 8'h03);
    rdc(IDX_FILL, 8'h03);
    chk("manual fill", fifo_fill_active, 1'b1);
    wr(IDX_FILL, 8'h01);
    rdc(IDX_FILL, 8'h01);
    chk("manual fill", fifo_fill_active, 1'b0);
    end_of_test(1'b0);
  end
endmodule
`default_nettype wire
